/* File: hdl/pio_map.vh */
// register offsets, reset values and widths for the parallel io port
`ifndef PIO_MAP_VH
`define PIO_MAP_VH
`define PIO_ADDR_W 3
`define PIO_OFS_DATA 3'h0
`define PIO_OFS_DIR 3'h1
`define PIO_OFS_MASK 3'h2
`define PIO_OFS_EDGE 3'h3
`define PIO_OFS_SET 3'h4
`define PIO_OFS_CLR 3'h5
`define PIO_REG_W 32
`define PIO_PORT_W 8
`define PIO_RST_ZERO 32'h0000_0000
`define PIO_RST_BIT 1'b0
`define PIO_ARM_ON 1'b1
`endif

/* File: hdl/pio_port.v */
// parallel io port with direction, edge capture, mask and bit set/clear
`timescale 1ns/1ps
`include "pio_map.vh"

module pio_port #(
    parameter WIDTH = `PIO_PORT_W
) (
    input wire clk,
    input wire rst_n,
    input wire [`PIO_ADDR_W-1:0] address,
    input wire chip_select,
    input wire write_n,
    input wire [`PIO_REG_W-1:0] writedata,
    output reg [`PIO_REG_W-1:0] readdata,
    input wire [WIDTH-1:0] pin_in,
    output wire [WIDTH-1:0] pin_out,
    output wire [WIDTH-1:0] pin_oe,
    output wire irq
);

    // register state; only the low WIDTH bits of each word are stored
    reg [WIDTH-1:0] out_value;
    reg [WIDTH-1:0] pin_direction;
    reg [WIDTH-1:0] irq_enable_mask;
    reg [WIDTH-1:0] edge_event_flags;
    reg [WIDTH-1:0] pin_prev;
    reg edge_armed;

    // next values
    reg [WIDTH-1:0] next_out_value;
    reg [WIDTH-1:0] next_pin_direction;
    reg [WIDTH-1:0] next_irq_enable_mask;
    reg [WIDTH-1:0] next_edge_event_flags;
    reg [WIDTH-1:0] next_pin_prev;
    reg next_edge_armed;
    reg [`PIO_REG_W-1:0] next_readdata;

    // decoded bus strobes and shared values
    wire wr_data;
    wire wr_dir;
    wire wr_mask;
    wire wr_edge;
    wire wr_set;
    wire wr_clr;
    wire rd_any;
    wire rd_data;
    wire rd_dir;
    wire rd_mask;
    wire rd_edge;
    wire [WIDTH-1:0] wlow;
    wire [WIDTH-1:0] edges;
    wire [WIDTH-1:0] no_bits;
    wire [WIDTH-1:0] read_value;

    // write strobe for one register slot
    function slot_write;
        input cs;
        input wn;
        input [`PIO_ADDR_W-1:0] addr;
        input [`PIO_ADDR_W-1:0] slot;
        begin
            slot_write = cs & ~wn & (addr == slot);
        end
    endfunction

    // any read cycle, whatever the slot
    function bus_read;
        input cs;
        input wn;
        begin
            bus_read = cs & wn;
        end
    endfunction

    // read strobe for one register slot
    function slot_read;
        input cs;
        input wn;
        input [`PIO_ADDR_W-1:0] addr;
        input [`PIO_ADDR_W-1:0] slot;
        begin
            slot_read = bus_read(cs, wn) & (addr == slot);
        end
    endfunction

    // upper bus bits are ignored on writes
    function [WIDTH-1:0] low_bits;
        input [`PIO_REG_W-1:0] word;
        begin
            low_bits = word[WIDTH-1:0];
        end
    endfunction

    // WIDTH must stay below the word width, the fill is never empty
    function [`PIO_REG_W-1:0] widen;
        input [WIDTH-1:0] value;
        begin
            widen = {{(`PIO_REG_W-WIDTH){`PIO_RST_BIT}}, value};
        end
    endfunction

    function [WIDTH-1:0] spread;
        input bit_in;
        begin
            spread = {WIDTH{bit_in}};
        end
    endfunction

    function [WIDTH-1:0] set_bits;
        input [WIDTH-1:0] cur;
        input [WIDTH-1:0] mask;
        begin
            set_bits = cur | mask;
        end
    endfunction

    function [WIDTH-1:0] clear_bits;
        input [WIDTH-1:0] cur;
        input [WIDTH-1:0] mask;
        begin
            clear_bits = cur & ~mask;
        end
    endfunction

    // set wins: a clear cannot hide an edge seen in the same cycle
    function [WIDTH-1:0] flag_update;
        input [WIDTH-1:0] flags;
        input [WIDTH-1:0] clear;
        input [WIDTH-1:0] fresh;
        begin
            flag_update = (flags & ~clear) | fresh;
        end
    endfunction

    // no edge until one sample is taken, so release from reset cannot fake one
    function [WIDTH-1:0] edge_detect;
        input armed;
        input [WIDTH-1:0] now;
        input [WIDTH-1:0] prev;
        begin
            if (armed) begin
                edge_detect = now ^ prev;
            end else begin
                edge_detect = {WIDTH{`PIO_RST_BIT}};
            end
        end
    endfunction

    // reads of slots four and up fall through to zero
    function [WIDTH-1:0] read_select;
        input hit_data;
        input hit_dir;
        input hit_mask;
        input hit_edge;
        input [WIDTH-1:0] pins;
        input [WIDTH-1:0] dir;
        input [WIDTH-1:0] mask;
        input [WIDTH-1:0] flags;
        begin
            read_select = (spread(hit_data) & pins)
                | (spread(hit_dir) & dir)
                | (spread(hit_mask) & mask)
                | (spread(hit_edge) & flags);
        end
    endfunction

    assign wr_data = slot_write(chip_select, write_n, address, `PIO_OFS_DATA);
    assign wr_dir = slot_write(chip_select, write_n, address, `PIO_OFS_DIR);
    assign wr_mask = slot_write(chip_select, write_n, address, `PIO_OFS_MASK);
    assign wr_edge = slot_write(chip_select, write_n, address, `PIO_OFS_EDGE);
    assign wr_set = slot_write(chip_select, write_n, address, `PIO_OFS_SET);
    assign wr_clr = slot_write(chip_select, write_n, address, `PIO_OFS_CLR);
    assign rd_any = bus_read(chip_select, write_n);
    assign rd_data = slot_read(chip_select, write_n, address, `PIO_OFS_DATA);
    assign rd_dir = slot_read(chip_select, write_n, address, `PIO_OFS_DIR);
    assign rd_mask = slot_read(chip_select, write_n, address, `PIO_OFS_MASK);
    assign rd_edge = slot_read(chip_select, write_n, address, `PIO_OFS_EDGE);
    assign wlow = low_bits(writedata);
    assign no_bits = {WIDTH{`PIO_RST_BIT}};
    assign edges = edge_detect(edge_armed, pin_in, pin_prev);
    assign read_value = read_select(rd_data, rd_dir, rd_mask, rd_edge,
        pin_in, pin_direction, irq_enable_mask, edge_event_flags);

    // pins drive only where the direction bit is one
    assign pin_out = out_value;
    assign pin_oe = pin_direction;
    assign irq = |(edge_event_flags & irq_enable_mask);

    always @* begin
        next_out_value = out_value;
        if (wr_data) begin
            next_out_value = wlow;
        end else if (wr_set) begin
            next_out_value = set_bits(out_value, wlow);
        end else if (wr_clr) begin
            next_out_value = clear_bits(out_value, wlow);
        end
    end

    always @* begin
        next_pin_direction = pin_direction;
        if (wr_dir) begin
            next_pin_direction = wlow;
        end
    end

    always @* begin
        next_irq_enable_mask = irq_enable_mask;
        if (wr_mask) begin
            next_irq_enable_mask = wlow;
        end
    end

    always @* begin
        if (wr_edge) begin
            next_edge_event_flags = flag_update(edge_event_flags, wlow, edges);
        end else begin
            next_edge_event_flags = flag_update(edge_event_flags, no_bits, edges);
        end
    end

    always @* begin
        next_pin_prev = pin_in;
        next_edge_armed = `PIO_ARM_ON;
    end

    // the last answer stands until the next read
    always @* begin
        next_readdata = readdata;
        if (rd_any) begin
            next_readdata = widen(read_value);
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_value <= {WIDTH{`PIO_RST_BIT}};
        end else begin
            out_value <= next_out_value;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_direction <= {WIDTH{`PIO_RST_BIT}};
        end else begin
            pin_direction <= next_pin_direction;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_enable_mask <= {WIDTH{`PIO_RST_BIT}};
        end else begin
            irq_enable_mask <= next_irq_enable_mask;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            edge_event_flags <= {WIDTH{`PIO_RST_BIT}};
        end else begin
            edge_event_flags <= next_edge_event_flags;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_prev <= {WIDTH{`PIO_RST_BIT}};
        end else begin
            pin_prev <= next_pin_prev;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            edge_armed <= `PIO_RST_BIT;
        end else begin
            edge_armed <= next_edge_armed;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            readdata <= `PIO_RST_ZERO;
        end else begin
            readdata <= next_readdata;
        end
    end

endmodule // pio_port

/* File: verif/pio_lamps.sv */
// lamp side of the port: a driven pin shows its level, an undriven one the outside world
`timescale 1ns/1ps
module pio_lamps (
    input wire [7:0] pin_out,
    input wire [7:0] pin_oe,
    input wire [7:0] ext,
    output wire [7:0] pin_in,
    output wire [7:0] lamp_lit
);
    // a one on a driven bit lights its lamp
    assign lamp_lit = pin_out & pin_oe;
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule // pio_lamps

/* File: verif/pio_chk_checker.sv */
// io port checker
`timescale 1ns/1ps
module pio_chk (
    input wire clk,
    input wire rst_n,
    input wire chip_select,
    input wire write_n,
    input wire irq,
    input wire [2:0] address,
    input wire [31:0] writedata,
    input wire [31:0] readdata,
    input wire [7:0] pin_in,
    input wire [7:0] pin_out,
    input wire [7:0] pin_oe
);
    wire w;
    wire d;
    wire [7:0] v;
    assign w = chip_select & ~write_n;
    assign d = chip_select & write_n;
    assign v = writedata[7:0];
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_DAT: assert property (w && address == 3'h0 |=> pin_out == $past(v)) else $error("data write");
    AST_DIR: assert property (w && address == 3'h1 |=> pin_oe == $past(v)) else $error("dir write");
    AST_SET: assert property (w && address == 3'h4 |=> pin_out == ($past(pin_out) | $past(v)))
        else $error("bit set");
    AST_CLR: assert property (w && address == 3'h5 |=> pin_out == ($past(pin_out) & ~$past(v)))
        else $error("bit clear");
    AST_IN: assert property (d && address == 3'h0 |=> readdata == $past(pin_in)) else $error("pin read");
    AST_MAP: assert property (d && address > 3'h3 |=> readdata == 32'h0000_0000) else $error("unmapped read");
    AST_IRQ: assert property (w && address == 3'h2 && v == 8'h00 |=> !irq) else $error("masked irq");
    // an edge between the two samples before a flag read must show in that read
    AST_EDG: assert property (d && address == 3'h3 && $past(rst_n, 2)
        |=> (($past(pin_in, 2) ^ $past(pin_in, 3)) & ~readdata[7:0]) == 8'h00) else $error("edge lost");
    AST_OUT_HOLD: assert property (!(w && (address == 3'h0 || address == 3'h4 || address == 3'h5))
        |=> $stable(pin_out)) else $error("output moved");
    AST_DIR_HOLD: assert property (!(w && address == 3'h1) |=> $stable(pin_oe)) else $error("dir moved");
endmodule // pio_chk

/* File: verif/tb_top.sv */
// random and directed register traffic checked against an integer model
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic chip_select = 1'b0;
    logic write_n = 1'b1;
    logic [2:0] address = 3'h0;
    logic [31:0] writedata = 32'h0000_0000;
    logic [7:0] ext = 8'h00;
    wire [31:0] readdata;
    wire [7:0] pin_in;
    wire [7:0] pin_out;
    wire [7:0] pin_oe;
    wire [7:0] lamp_lit;
    wire irq;
    int bad_count = 0;
    int comparisons = 0;
    // model words: out, dir, mask, flags, previous pins, read word
    int r[6];
    int armed;

    always #12.5 clk = ~clk;

    pio_port dut_u (
        .clk(clk),
        .rst_n(rst_n),
        .address(address),
        .chip_select(chip_select),
        .write_n(write_n),
        .writedata(writedata),
        .readdata(readdata),
        .pin_in(pin_in),
        .pin_out(pin_out),
        .pin_oe(pin_oe),
        .irq(irq)
    );

    pio_lamps lamps_u (
        .pin_out(pin_out),
        .pin_oe(pin_oe),
        .ext(ext),
        .pin_in(pin_in),
        .lamp_lit(lamp_lit)
    );

    task note_bad(input string what);
        bad_count++;
        $display("MISMATCH %0t %s", $time, what);
    endtask

    task chk_read(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            note_bad("read data");
        end
    endtask

    task chk_pins(input logic [7:0] got, input logic [7:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            note_bad(what);
        end
    endtask

    task chk_irq(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            note_bad("interrupt");
        end
    endtask

    task conclude;
        $display("%0d comparisons, %0d mismatches", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // the model applies each cycle the way the rules read
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r = '{default: 0};
            armed = 0;
        end else begin
            if (chip_select && write_n) begin
                if (address == 0) begin
                    r[5] = pin_in;
                end else if (address < 4) begin
                    r[5] = r[address];
                end else begin
                    r[5] = 0;
                end
            end
            if (chip_select && !write_n) begin
                case (address)
                    0: r[0] = writedata[7:0];
                    1: r[1] = writedata[7:0];
                    2: r[2] = writedata[7:0];
                    3: r[3] = r[3] & ~writedata[7:0];
                    4: r[0] = r[0] | writedata[7:0];
                    5: r[0] = r[0] & ~writedata[7:0];
                    default: r[5] = r[5];
                endcase
            end
            if (armed) begin
                r[3] = r[3] | (pin_in ^ r[4]);
            end
            r[4] = pin_in;
            armed = 1;
        end
    end

    always @(negedge clk) begin
        chk_read(readdata, r[5]);
        chk_pins(pin_out, r[0], "output");
        chk_pins(pin_oe, r[1], "direction");
        chk_pins(lamp_lit, r[0] & r[1], "lamps");
        chk_irq(irq, (r[3] & r[2]) != 0);
    end

    task access(input logic wn, input logic [2:0] a, input logic [31:0] d);
        @(posedge clk);
        chip_select <= 1'b1;
        write_n <= wn;
        address <= a;
        writedata <= d;
        @(posedge clk);
        chip_select <= 1'b0;
        write_n <= 1'b1;
    endtask

    task random_traffic(input int cycles);
        repeat (cycles) begin
            @(posedge clk);
            chip_select <= 1'($urandom);
            write_n <= 1'($urandom);
            address <= 3'($urandom);
            writedata <= $urandom;
            ext <= 8'($urandom);
        end
        @(posedge clk);
        chip_select <= 1'b0;
        write_n <= 1'b1;
    endtask

    // pins change once as reset is applied and then hold, which must not leave a false edge
    task pulse_reset;
        @(posedge clk);
        rst_n <= 1'b0;
        ext <= 8'($urandom);
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
    endtask

    task directed_test;
        access(1'b0, 3'h1, 32'h0000_00ff);
        access(1'b0, 3'h0, 32'h0000_00ff);
        access(1'b1, 3'h0, 32'h0000_0000);
        access(1'b0, 3'h5, 32'h0000_0081);
        access(1'b0, 3'h4, 32'h0000_0001);
        access(1'b0, 3'h1, 32'h0000_0000);
        access(1'b0, 3'h2, 32'h0000_00ff);
        @(posedge clk);
        ext <= 8'h5a;
        access(1'b1, 3'h3, 32'h0000_0000);
        access(1'b0, 3'h2, 32'h0000_0000);
        access(1'b0, 3'h3, 32'h0000_00ff);
        access(1'b1, 3'h3, 32'h0000_0000);
        access(1'b1, 3'h6, 32'h0000_0000);
        access(1'b0, 3'h7, 32'h0000_00ff);
        access(1'b1, 3'h2, 32'h0000_0000);
    endtask

    initial begin
        void'($urandom(32'h0000_0a26));
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        directed_test;
        $display("test directed done");
        random_traffic(2000);
        $display("test random done");
        pulse_reset;
        access(1'b1, 3'h3, 32'h0000_0000);
        directed_test;
        $display("test reset done");
        random_traffic(1000);
        $display("test random after reset done");
        conclude;
    end
endmodule // tb_top

bind pio_port pio_chk chk_u (
    .clk(clk),
    .rst_n(rst_n),
    .chip_select(chip_select),
    .write_n(write_n),
    .irq(irq),
    .address(address),
    .writedata(writedata),
    .readdata(readdata),
    .pin_in(pin_in),
    .pin_out(pin_out),
    .pin_oe(pin_oe)
);
